// *** rtl/mat_address_table.v ***
// Address table of a managed switch: learning, aging, static entries, clear,
// ordered read-out and lookup, all served by one sequential scan of the table.
// Assumes the frame datapath and management logic share clk_sys and hold
// their request stable while valid is high and ready is low.
//
// Contract
// - Every received frame's source address creates or refreshes a dynamic entry, unless it matches a static entry or the table is full.
// - A dynamic entry not refreshed within the configurable aging interval is deleted; the sweep deletes it after between one and two intervals.
// - The table stores at most 8192 entries.
// - Read-out returns entries in ascending order of VLAN number, then address.
// - An entry holds an index, the address, its member ports, the VLAN and a static flag.
// - A clear command removes every dynamic entry.
// - Static entries are never aged out.
// - Management creates a static entry from address, port and VLAN; lookups then give that port.
`timescale 1ns/1ps
`include "mat_regs.vh"
module mat_address_table #(
  parameter [`MAT_TICK_CNT_W-1:0] TICK_CYCLES = `MAT_TICK_CYCLES
) (
  input  wire                   clk_sys,                   // System clock, 50 MHz.
  input  wire                   reset,                     // Asynchronous reset, active high.
  input  wire                   learn_valid,               // Frame source address offered.
  output wire                   learn_ready,               // Learn request taken this cycle.
  input  wire [`MAT_ADDR_W-1:0] frame_source_address,      // Source address of the frame.
  input  wire [`MAT_VLAN_W-1:0] learn_vlan_tag_number,     // VLAN of the frame.
  input  wire [`MAT_PORT_W-1:0] learn_port,                // Ingress port number.
  input  wire                   mgmt_valid,                // Management command offered.
  output wire                   mgmt_ready,                // Management command taken.
  input  wire [`MAT_CMD_W-1:0]  mgmt_op,                   // Static, clear, read or lookup.
  input  wire [`MAT_ADDR_W-1:0] mgmt_address,              // Address operand.
  input  wire [`MAT_VLAN_W-1:0] mgmt_vlan_tag_number,      // VLAN operand.
  input  wire [`MAT_PORT_W-1:0] mgmt_port,                 // Port operand for static add.
  input  wire                   mgmt_first,                // Read: start from the lowest key.
  input  wire [`MAT_AGE_W-1:0]  age_seconds,               // Aging interval, zero disables.
  output reg                    resp_valid,                // One-cycle end of command pulse.
  output reg  [`MAT_CMD_W-1:0]  resp_op,                   // Command that ended.
  output reg                    resp_found,                // Entry found or written.
  output reg  [`MAT_IDX_W-1:0]  resp_index,                // Entry index.
  output reg  [`MAT_ADDR_W-1:0] resp_address,              // Entry address.
  output reg  [`MAT_VLAN_W-1:0] resp_vlan_tag_number,      // Entry VLAN.
  output reg  [`MAT_PORTS-1:0]  resp_ports,                // Entry member ports.
  output reg                    resp_static,               // Entry is static.
  output wire                   busy                       // Scan in progress.
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SCAN = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [`MAT_KEY_W-1:0] key_mem    [0:`MAT_DEPTH-1];
  reg [`MAT_PORTS-1:0] port_mem   [0:`MAT_DEPTH-1];
  reg                  ent_valid  [0:`MAT_DEPTH-1];
  reg                  ent_static [0:`MAT_DEPTH-1];
  reg                  ent_hit    [0:`MAT_DEPTH-1];

  reg [2:0]             state;
  reg [`MAT_CMD_W-1:0]  cmd;
  reg [`MAT_KEY_W-1:0]  cmd_key;
  reg [`MAT_PORT_W-1:0] cmd_port;
  reg                   cmd_first;
  reg [`MAT_IDX_W-1:0]  idx;
  reg                   sel_ok;
  reg [`MAT_IDX_W-1:0]  sel_idx;
  reg [`MAT_KEY_W-1:0]  best_key;
  reg                   free_ok;
  reg [`MAT_IDX_W-1:0]  free_idx;
  reg [`MAT_AGE_W-1:0]  sec_cnt;
  reg                   age_pend;
  integer               i;

  wire                  idle      = state[0];
  wire                  start_mg  = idle && mgmt_valid;
  wire                  start_age = idle && !mgmt_valid && age_pend;
  wire [`MAT_KEY_W-1:0] cur_key   = key_mem[idx];
  wire                  cur_valid = ent_valid[idx];
  wire                  cur_dyn   = ent_valid[idx] && !ent_static[idx];
  wire [`MAT_PORTS-1:0] port_mask = {{(`MAT_PORTS-1){1'b0}}, 1'b1} << cmd_port;
  wire                  tick;

  // Learning yields to management and to a due aging sweep so those never starve.
  assign mgmt_ready  = idle;
  assign learn_ready = idle && !mgmt_valid && !age_pend;
  assign busy        = !idle;

  mat_tick_div #(
    .W      (`MAT_TICK_CNT_W),
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (tick)
  );

  // A sweep every interval deletes dynamic entries not refreshed since the previous
  // sweep, so an idle entry lives between one and two intervals.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sec_cnt  <= {`MAT_AGE_W{1'b0}};
      age_pend <= 1'b0;
    end else begin
      if (tick && age_seconds != {`MAT_AGE_W{1'b0}}) begin
        if (sec_cnt + {{(`MAT_AGE_W-1){1'b0}}, 1'b1} >= age_seconds) begin
          sec_cnt  <= {`MAT_AGE_W{1'b0}};
          age_pend <= 1'b1;
        end else begin
          sec_cnt <= sec_cnt + {{(`MAT_AGE_W-1){1'b0}}, 1'b1};
        end
      end else if (start_age) begin
        age_pend <= 1'b0;
      end
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state                <= ST_IDLE;
      cmd                  <= `MAT_CMD_LEARN;
      cmd_key              <= {`MAT_KEY_W{1'b0}};
      cmd_port             <= {`MAT_PORT_W{1'b0}};
      cmd_first            <= 1'b0;
      idx                  <= {`MAT_IDX_W{1'b0}};
      sel_ok               <= 1'b0;
      sel_idx              <= {`MAT_IDX_W{1'b0}};
      best_key             <= {`MAT_KEY_W{1'b0}};
      free_ok              <= 1'b0;
      free_idx             <= {`MAT_IDX_W{1'b0}};
      resp_valid           <= 1'b0;
      resp_op              <= `MAT_CMD_LEARN;
      resp_found           <= 1'b0;
      resp_index           <= {`MAT_IDX_W{1'b0}};
      resp_address         <= {`MAT_ADDR_W{1'b0}};
      resp_vlan_tag_number <= {`MAT_VLAN_W{1'b0}};
      resp_ports           <= {`MAT_PORTS{1'b0}};
      resp_static          <= 1'b0;
      for (i = 0; i < `MAT_DEPTH; i = i + 1) begin
        ent_valid[i]  <= 1'b0;
        ent_static[i] <= 1'b0;
        ent_hit[i]    <= 1'b0;
      end
    end else begin
      resp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          idx     <= {`MAT_IDX_W{1'b0}};
          sel_ok  <= 1'b0;
          free_ok <= 1'b0;
          if (start_mg) begin
            cmd       <= mgmt_op;
            cmd_key   <= {mgmt_vlan_tag_number, mgmt_address};
            cmd_port  <= mgmt_port;
            cmd_first <= mgmt_first;
            state     <= ST_SCAN;
          end else if (start_age) begin
            cmd   <= `MAT_CMD_AGE;
            state <= ST_SCAN;
          end else if (learn_valid) begin
            cmd      <= `MAT_CMD_LEARN;
            cmd_key  <= {learn_vlan_tag_number, frame_source_address};
            cmd_port <= learn_port;
            state    <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          case (cmd)
            `MAT_CMD_LEARN, `MAT_CMD_STATIC, `MAT_CMD_LOOKUP: begin
              if (cur_valid && cur_key == cmd_key) begin
                sel_ok  <= 1'b1;
                sel_idx <= idx;
              end
              if (!cur_valid && !free_ok) begin
                free_ok  <= 1'b1;
                free_idx <= idx;
              end
            end
            `MAT_CMD_READ: begin
              // Smallest key above the previous one; VLAN sits above the address bits.
              if (cur_valid && (cmd_first || cur_key > cmd_key) &&
                  (!sel_ok || cur_key < best_key)) begin
                sel_ok   <= 1'b1;
                sel_idx  <= idx;
                best_key <= cur_key;
              end
            end
            `MAT_CMD_CLEAR: begin
              if (cur_dyn) begin
                ent_valid[idx] <= 1'b0;
              end
            end
            `MAT_CMD_AGE: begin
              if (cur_dyn) begin
                if (ent_hit[idx]) begin
                  ent_hit[idx] <= 1'b0;
                end else begin
                  ent_valid[idx] <= 1'b0;
                end
              end
            end
            default: begin
            end
          endcase
          if (idx == `MAT_LAST_IDX) begin
            state <= ST_DONE;
          end else begin
            idx <= idx + {{(`MAT_IDX_W-1){1'b0}}, 1'b1};
          end
        end
        ST_DONE: begin
          state      <= ST_IDLE;
          resp_valid <= 1'b1;
          resp_op    <= cmd;
          resp_found <= sel_ok;
          resp_index <= sel_idx;
          // Stored contents first; a written entry overrides them below, since the
          // memory still holds the old value at this edge.
          if (sel_ok) begin
            resp_address         <= key_mem[sel_idx][`MAT_ADDR_W-1:0];
            resp_vlan_tag_number <= key_mem[sel_idx][`MAT_KEY_W-1:`MAT_ADDR_W];
            resp_ports           <= port_mem[sel_idx];
            resp_static          <= ent_static[sel_idx];
          end else begin
            resp_address         <= {`MAT_ADDR_W{1'b0}};
            resp_vlan_tag_number <= {`MAT_VLAN_W{1'b0}};
            resp_ports           <= {`MAT_PORTS{1'b0}};
            resp_static          <= 1'b0;
          end
          case (cmd)
            `MAT_CMD_LEARN: begin
              resp_found <= sel_ok || free_ok;
              resp_index <= sel_ok ? sel_idx : free_idx;
              if (sel_ok) begin
                if (!ent_static[sel_idx]) begin
                  port_mem[sel_idx] <= port_mask;
                  ent_hit[sel_idx]  <= 1'b1;
                  resp_ports        <= port_mask;
                end
              end else if (free_ok) begin
                ent_valid[free_idx]  <= 1'b1;
                ent_static[free_idx] <= 1'b0;
                ent_hit[free_idx]    <= 1'b1;
                key_mem[free_idx]    <= cmd_key;
                port_mem[free_idx]   <= port_mask;
                resp_address         <= cmd_key[`MAT_ADDR_W-1:0];
                resp_vlan_tag_number <= cmd_key[`MAT_KEY_W-1:`MAT_ADDR_W];
                resp_ports           <= port_mask;
                resp_static          <= 1'b0;
              end
            end
            `MAT_CMD_STATIC: begin
              resp_found <= sel_ok || free_ok;
              resp_index <= sel_ok ? sel_idx : free_idx;
              if (sel_ok || free_ok) begin
                ent_valid[sel_ok ? sel_idx : free_idx]  <= 1'b1;
                ent_static[sel_ok ? sel_idx : free_idx] <= 1'b1;
                ent_hit[sel_ok ? sel_idx : free_idx]    <= 1'b0;
                key_mem[sel_ok ? sel_idx : free_idx]    <= cmd_key;
                port_mem[sel_ok ? sel_idx : free_idx]   <= port_mask;
                resp_address         <= cmd_key[`MAT_ADDR_W-1:0];
                resp_vlan_tag_number <= cmd_key[`MAT_KEY_W-1:`MAT_ADDR_W];
                resp_ports           <= port_mask;
                resp_static          <= 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // mat_address_table

// *** rtl/mat_regs.vh ***
// Constants of the switch address table: sizes, command codes and timing counts.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef MAT_REGS_VH
`define MAT_REGS_VH

`define MAT_DEPTH          8192
`define MAT_IDX_W          13
`define MAT_LAST_IDX       13'h1FFF
`define MAT_ADDR_W         48
`define MAT_VLAN_W         12
`define MAT_KEY_W          60
`define MAT_PORTS          10
`define MAT_PORT_W         4
`define MAT_AGE_W          16

`define MAT_CMD_W          3
`define MAT_CMD_LEARN      3'h0
`define MAT_CMD_STATIC     3'h1
`define MAT_CMD_CLEAR      3'h2
`define MAT_CMD_READ       3'h3
`define MAT_CMD_LOOKUP     3'h4
`define MAT_CMD_AGE        3'h5

`define MAT_CLK_PERIOD_NS  20
`define MAT_AGE_UNIT_NS    1000000000
// One aging unit of 1 s at the 20 ns clock, sized to the tick divider's counter.
`define MAT_TICK_CYCLES    26'h2FAF080
`define MAT_TICK_CNT_W     26

`endif

// *** rtl/mat_tick_div.v ***
// Divider that turns the system clock into a one-cycle enable per aging unit.
// Assumes a free-running clk_sys and CYCLES no larger than 2**W.
`timescale 1ns/1ps
module mat_tick_div #(
  parameter         W      = 26,
  parameter [W-1:0] CYCLES = 26'h2FAF080
) (
  input  wire clk_sys, // System clock.
  input  wire reset,   // Asynchronous reset, active high.
  output reg  tick     // One-cycle pulse every CYCLES cycles.
);

  reg [W-1:0] count;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (count == CYCLES - {{(W-1){1'b0}}, 1'b1}) begin
      count <= {W{1'b0}};
      tick  <= 1'b1;
    end else begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end

endmodule // mat_tick_div

// *** bench/mat_address_table_monitor.sv ***
// Checker of the address table's handshake timing and response contents.
// Assumes a bind to mat_address_table; it sees only the ports of that module.
`timescale 1ns/1ps
`include "mat_regs.vh"
module mat_address_table_monitor (
  input wire                   clk_sys,      // System clock.
  input wire                   reset,        // Asynchronous reset, active high.
  input wire                   learn_valid,  // Learn request.
  input wire                   learn_ready,  // Learn taken.
  input wire                   mgmt_valid,   // Management request.
  input wire                   mgmt_ready,   // Management taken.
  input wire                   resp_valid,   // End of command.
  input wire [`MAT_CMD_W-1:0]  resp_op,      // Command that ended.
  input wire                   resp_found,   // Entry found or written.
  input wire [`MAT_ADDR_W-1:0] resp_address, // Entry address.
  input wire [`MAT_PORTS-1:0]  resp_ports,   // Entry ports.
  input wire                   resp_static,  // Entry is static.
  input wire                   busy          // Scan in progress.
);
  // Counts from the last idle cycle, so internal age sweeps are timed as well.
  reg [13:0] cnt;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) cnt <= 14'h0001;
    else if (!busy) cnt <= 14'h0001;
    else cnt <= cnt + 14'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_RESP_LAT: assert property (resp_valid |-> cnt == 14'h2002)
    else $error("response not 8194 cycles after take");
  AST_READY: assert property ((mgmt_ready == !busy) &&
    (!(busy || mgmt_valid) || !learn_ready))
    else $error("ready while busy or behind management");
  AST_PULSE: assert property (resp_valid |=> !resp_valid)
    else $error("response longer than one cycle");
  AST_TAKE: assert property ((mgmt_valid && mgmt_ready) || (learn_valid && learn_ready) |=> busy [*8])
    else $error("taken request did not start a scan");
  AST_CLEAR_NONE: assert property (resp_valid && (resp_op == `MAT_CMD_CLEAR || resp_op == `MAT_CMD_AGE) |-> !resp_found)
    else $error("clear or sweep reported an entry");
  AST_MISS_EMPTY: assert property (resp_valid && !resp_found |-> resp_ports == 10'h000 && !resp_static && resp_address == 48'h0)
    else $error("empty response carries entry data");
  AST_HOLD: assert property (!resp_valid |-> $stable(resp_ports) && $stable(resp_static) && $stable(resp_address))
    else $error("response fields changed between commands");
  AST_LEARN_MASK: assert property (resp_valid && resp_op == `MAT_CMD_LEARN && !resp_static |-> $onehot0(resp_ports))
    else $error("learned entry has more than one port");
endmodule // mat_address_table_monitor

// *** bench/mat_frame_src.sv ***
// Model of the frame datapath that offers source addresses for learning.
// Assumes the bench raises go for one cycle per frame; it drives at falling edges.
`timescale 1ns/1ps
module mat_frame_src (
  input  wire        clk_sys, // System clock.
  input  wire        go,      // Offer one frame.
  input  wire [47:0] addr,    // Address to offer.
  input  wire [11:0] vlan,    // VLAN to offer.
  input  wire [3:0]  port,    // Ingress port to offer.
  input  wire        ready,   // Table ready.
  output reg         valid,   // Frame offered.
  output reg  [47:0] sa,      // Offered address.
  output reg  [11:0] sv,      // Offered VLAN.
  output reg  [3:0]  sp       // Offered port.
);
  reg took = 1'b0;
  initial {valid, sa, sv, sp} = 65'h0;
  always @(posedge clk_sys) took <= valid && ready;
  // Operands are inverted after release so stale data never looks like a new frame.
  always @(negedge clk_sys) begin
    if (valid && took) {valid, sa, sv, sp} <= {1'b0, ~sa, ~sv, ~sp};
    else if (!valid && go) {valid, sa, sv, sp} <= {1'b1, addr, vlan, port};
  end
endmodule // mat_frame_src

// *** bench/mat_address_table_tb_top.sv ***
// Testbench of the address table: learning, static entries, ordered read, clear, aging.
// Assumes the frame model beside it; management is driven here at falling edges.
`timescale 1ns/1ps
`include "mat_regs.vh"
module mat_address_table_tb_top;
  reg        clk_sys = 1'b0, reset = 1'b1, go = 1'b0, mgmt_valid = 1'b0, mgmt_first = 1'b0;
  reg [2:0]  mgmt_op = 3'h0;
  reg [47:0] mgmt_address = 48'h0, l_addr = 48'h0;
  reg [11:0] mgmt_vlan_tag_number = 12'h0, l_vlan = 12'h0;
  reg [3:0]  mgmt_port = 4'h0, l_port = 4'h0;
  reg [15:0] age_seconds = 16'h0;
  wire       learn_valid, learn_ready, mgmt_ready, resp_valid, resp_found, resp_static, busy;
  wire [47:0] fsa, resp_address;
  wire [11:0] lvt, resp_vlan_tag_number;
  wire [3:0]  lp;
  wire [2:0]  resp_op;
  wire [12:0] resp_index;
  wire [9:0]  resp_ports;
  integer    n_errors = 0, checks = 0, cycles = 0;
  localparam [47:0] ADR_A = 48'h0000_1111_2222, ADR_B = 48'h0000_3333_4444;
  always #10 clk_sys = ~clk_sys;
  mat_frame_src i_src (.clk_sys(clk_sys), .go(go), .addr(l_addr), .vlan(l_vlan), .port(l_port),
    .ready(learn_ready), .valid(learn_valid), .sa(fsa), .sv(lvt), .sp(lp));
  mat_address_table #(.TICK_CYCLES(26'h0000014)) i_dut (.clk_sys(clk_sys), .reset(reset),
    .learn_valid(learn_valid), .learn_ready(learn_ready), .frame_source_address(fsa),
    .learn_vlan_tag_number(lvt), .learn_port(lp), .mgmt_valid(mgmt_valid),
    .mgmt_ready(mgmt_ready), .mgmt_op(mgmt_op), .mgmt_address(mgmt_address),
    .mgmt_vlan_tag_number(mgmt_vlan_tag_number), .mgmt_port(mgmt_port),
    .mgmt_first(mgmt_first), .age_seconds(age_seconds), .resp_valid(resp_valid),
    .resp_op(resp_op), .resp_found(resp_found), .resp_index(resp_index),
    .resp_address(resp_address), .resp_vlan_tag_number(resp_vlan_tag_number),
    .resp_ports(resp_ports), .resp_static(resp_static), .busy(busy));
  task give_verdict;
    begin
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 105000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  task chk(input string name, input [63:0] seen, input [63:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Called at a falling edge; holding valid before the idle edge beats a queued sweep.
  task rsp(input [2:0] op);
    begin
      @(negedge clk_sys);
      while (!(resp_valid === 1'b1 && resp_op === op)) @(negedge clk_sys);
    end
  endtask
  task run(input [2:0] op, input [47:0] a, input [11:0] v, input [3:0] p, input f);
    begin
      {mgmt_op, mgmt_address, mgmt_vlan_tag_number, mgmt_port, mgmt_first} = {op, a, v, p, f};
      mgmt_valid = 1'b1;
      while (mgmt_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      mgmt_valid = 1'b0;
      {mgmt_address, mgmt_port} = ~{a, p};
      rsp(op);
    end
  endtask
  task lrn(input [47:0] a, input [11:0] v, input [3:0] p);
    begin
      {l_addr, l_vlan, l_port} = {a, v, p};
      go <= 1'b1;
      @(negedge clk_sys);
      go <= 1'b0;
      rsp(`MAT_CMD_LEARN);
    end
  endtask
  task ent(input f, input [47:0] a, input [11:0] v, input [9:0] pm, input s);
    begin
      chk("found", 64'(resp_found), 64'(f));
      chk("address", 64'(resp_address), 64'(a));
      chk("vlan", 64'(resp_vlan_tag_number), 64'(v));
      chk("ports", 64'(resp_ports), 64'(pm));
      chk("static", 64'(resp_static), 64'(s));
    end
  endtask
  task t_learn;
    begin
      lrn(ADR_A, 12'h001, 4'h3);
      ent(1'b1, ADR_A, 12'h001, 10'h008, 1'b0);
      chk("index", 64'(resp_index), 64'h0);
    end
  endtask
  task t_static_read;
    begin
      run(`MAT_CMD_STATIC, ADR_B, 12'h000, 4'h2, 1'b0);
      chk("static add", 64'(resp_found), 64'h1);
      ent(1'b1, ADR_B, 12'h000, 10'h004, 1'b1);
      lrn(ADR_B, 12'h000, 4'h5);
      ent(1'b1, ADR_B, 12'h000, 10'h004, 1'b1);
      chk("static kept index", 64'(resp_index), 64'h1);
      run(`MAT_CMD_READ, 48'h0, 12'h000, 4'h0, 1'b1);
      ent(1'b1, ADR_B, 12'h000, 10'h004, 1'b1);
      chk("read index", 64'(resp_index), 64'h1);
      run(`MAT_CMD_READ, ADR_B, 12'h000, 4'h0, 1'b0);
      ent(1'b1, ADR_A, 12'h001, 10'h008, 1'b0);
      chk("next index", 64'(resp_index), 64'h0);
    end
  endtask
  task t_clear;
    begin
      run(`MAT_CMD_CLEAR, 48'h0, 12'h000, 4'h0, 1'b0);
      run(`MAT_CMD_LOOKUP, ADR_A, 12'h001, 4'h0, 1'b0);
      chk("cleared", 64'(resp_found), 64'h0);
    end
  endtask
  task t_age;
    begin
      lrn(ADR_A, 12'h001, 4'h3);
      chk("relearn", 64'(resp_found), 64'h1);
      age_seconds = 16'h0001;
      rsp(`MAT_CMD_AGE);
      rsp(`MAT_CMD_AGE);
      age_seconds = 16'h0000;
      run(`MAT_CMD_LOOKUP, ADR_A, 12'h001, 4'h0, 1'b0);
      chk("aged", 64'(resp_found), 64'h0);
      run(`MAT_CMD_LOOKUP, ADR_B, 12'h000, 4'h0, 1'b0);
      ent(1'b1, ADR_B, 12'h000, 10'h004, 1'b1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    t_learn;
    t_static_read;
    t_clear;
    t_age;
    give_verdict;
  end
endmodule // mat_address_table_tb_top
bind mat_address_table mat_address_table_monitor i_mon (.clk_sys(clk_sys), .reset(reset),
  .learn_valid(learn_valid), .learn_ready(learn_ready), .mgmt_valid(mgmt_valid),
  .mgmt_ready(mgmt_ready), .resp_valid(resp_valid), .resp_op(resp_op),
  .resp_found(resp_found), .resp_address(resp_address), .resp_ports(resp_ports),
  .resp_static(resp_static), .busy(busy));
